/* design/sram_ctrl_pkg.sv */
// Constants for the static RAM host controller
`default_nettype none
package sram_ctrl_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH = 2048;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Slowest grade figures, in ns
  localparam int unsigned T_CYCLE_NS = 200;
  localparam int unsigned T_ADDR_SETUP_NS = 20;
  localparam int unsigned T_WRITE_PULSE_NS = 120;
  localparam int unsigned T_WRITE_REC_NS = 10;
  localparam int unsigned T_OUT_HIZ_NS = 60;
  localparam int unsigned T_DATA_HOLD_NS = 10;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WPULSE_CYC = CNT_W'((T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'((T_WRITE_REC_NS + T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_CYC = CNT_W'((T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HIZ_CYC = CNT_W'((T_OUT_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_RECOV,
    ST_TURN
  } state_e;
endpackage : sram_ctrl_pkg
`default_nettype wire

/* design/sram_host_ctrl.sv */
// Host controller driving a 2048x8 asynchronous static RAM
// Behaviour
// - The write strobe is held high throughout every read.
// - The address is valid no later than the falling edge of select.
// - While select is low every address line is driven to a valid level.
// - The address is held through the write recovery counted from the first rising strobe.
// - The host never drives data while the memory may still drive the bus.
// - With select low outside a write window, except in write recovery, the host treats the bus as memory-driven.
`default_nettype none
module sram_host_ctrl
  import sram_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_sel_b,
  output logic mem_oe_b,
  output logic mem_we_b,
  input wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  state_e state;
  state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_req_ready;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic [ADDR_W-1:0] next_mem_addr;
  logic next_mem_sel_b;
  logic next_mem_oe_b;
  logic next_mem_we_b;
  logic [DATA_W-1:0] next_mem_data_out;
  logic next_mem_data_oe;
  logic cnt_done;
  logic turn_done;
  logic take;

  assign cnt_done = (cnt == CNT_ONE);
  assign turn_done = cnt_done || (cnt == CNT_ZERO);
  assign take = (state == ST_IDLE) && req_valid && req_ready;

  // Sequencer: phase and its cycle count
  always_comb begin
    next_state = state;
    next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
    case (state)
      ST_IDLE: begin
        if (take) begin
          if (req_write) begin
            next_cnt = SETUP_CYC;
            next_state = ST_WR_SETUP;
          end else begin
            next_cnt = READ_CYC;
            next_state = ST_RD;
          end
        end
      end
      ST_RD: begin
        if (cnt_done) begin
          next_cnt = HIZ_CYC;
          next_state = ST_TURN;
        end
      end
      ST_WR_SETUP: begin
        if (cnt_done) begin
          next_cnt = WPULSE_CYC;
          next_state = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          next_cnt = RECOV_CYC;
          next_state = ST_WR_RECOV;
        end
      end
      ST_WR_RECOV: begin
        if (cnt_done) begin
          next_cnt = CNT_ONE;
          next_state = ST_TURN;
        end
      end
      ST_TURN: begin
        // Memory output release time before the bus is used again
        if (turn_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Request handshake and read response
  always_comb begin
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    case (state)
      ST_IDLE: begin
        next_req_ready = !take;
      end
      ST_RD: begin
        if (cnt_done) begin
          // Sample after full access time, equal to the cycle time
          next_rsp_rdata = mem_data_in;
          next_rsp_valid = 1'b1;
        end
      end
      ST_TURN: begin
        next_req_ready = turn_done;
      end
      default: begin
        next_req_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= DATA_RST;
    end else begin
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  // Memory pins
  always_comb begin
    next_mem_addr = mem_addr;
    next_mem_sel_b = mem_sel_b;
    next_mem_oe_b = mem_oe_b;
    next_mem_we_b = 1'b1;
    next_mem_data_out = mem_data_out;
    next_mem_data_oe = 1'b0;
    case (state)
      ST_IDLE: begin
        next_mem_sel_b = 1'b1;
        next_mem_oe_b = 1'b1;
        if (take) begin
          // Address out with select in the same edge, never before it
          next_mem_addr = req_addr;
          next_mem_sel_b = 1'b0;
          if (req_write) begin
            // Select low and output enable high first, strobe falls later
            next_mem_oe_b = 1'b1;
            next_mem_data_out = req_wdata;
          end else begin
            next_mem_oe_b = 1'b0;
            next_mem_we_b = 1'b1;
          end
        end
      end
      ST_RD: begin
        next_mem_we_b = 1'b1;
        next_mem_data_oe = 1'b0;
        if (cnt_done) begin
          next_mem_sel_b = 1'b1;
          next_mem_oe_b = 1'b1;
        end
      end
      ST_WR_SETUP: begin
        next_mem_data_oe = 1'b0;
        if (cnt_done) begin
          next_mem_we_b = 1'b0;
          next_mem_data_oe = 1'b1;
        end
      end
      ST_WR_PULSE: begin
        next_mem_we_b = 1'b0;
        next_mem_data_oe = 1'b1;
        if (cnt_done) begin
          // Strobe rises first; recovery counted from here
          next_mem_we_b = 1'b1;
        end
      end
      ST_WR_RECOV: begin
        // Address and data held through recovery and hold time
        next_mem_data_oe = 1'b1;
        if (cnt_done) begin
          next_mem_data_oe = 1'b0;
          next_mem_sel_b = 1'b1;
        end
      end
      ST_TURN: begin
        // Bus left undriven while the memory releases it
        next_mem_data_oe = 1'b0;
      end
      default: begin
        next_mem_sel_b = 1'b1;
        next_mem_oe_b = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr <= ADDR_RST;
      mem_sel_b <= 1'b1;
      mem_oe_b <= 1'b1;
      mem_we_b <= 1'b1;
      mem_data_out <= DATA_RST;
      mem_data_oe <= 1'b0;
    end else begin
      mem_addr <= next_mem_addr;
      mem_sel_b <= next_mem_sel_b;
      mem_oe_b <= next_mem_oe_b;
      mem_we_b <= next_mem_we_b;
      mem_data_out <= next_mem_data_out;
      mem_data_oe <= next_mem_data_oe;
    end
  end
endmodule : sram_host_ctrl
`default_nettype wire

/* dv/sram_model.sv */
// Behavioural static RAM facing the host controller
`default_nettype none
module sram_model
  import sram_ctrl_pkg::*;
(
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_sel_b,
  input wire logic mem_oe_b,
  input wire logic mem_we_b,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  output logic [DATA_W-1:0] mem_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] last = 8'h00;
  wire logic drv = !mem_sel_b && !mem_oe_b && mem_we_b;
  wire logic [DATA_W-1:0] val = mem_data_oe ? mem_data_out : mem[mem_addr];
  // Level write in the overlap, no clock
  always @* if (!mem_sel_b && !mem_we_b) mem[mem_addr] = mem_data_in;
  always @* if (drv || mem_data_oe) last = val;
  // Released bus shows the inverse of its last value
  assign mem_data_in = (drv || mem_data_oe) ? val : ~last;
endmodule : sram_model
`default_nettype wire

/* dv/sram_host_ctrl_sva.sv */
// Checker of the host side RAM protocol
`default_nettype none
module sram_host_ctrl_sva
  import sram_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_sel_b,
  input wire logic mem_oe_b,
  input wire logic mem_we_b,
  input wire logic mem_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_read_we_high:
  assert property ($fell(mem_oe_b) |-> (mem_we_b && !mem_oe_b) [*4] ##1 (mem_oe_b && rsp_valid)) else $error("read");
  a_addr_held:
  assert property (!mem_sel_b && !$past(mem_sel_b) |-> $stable(mem_addr)) else $error("addr");
  a_rec_hold:
  assert property ($rose(mem_we_b) |=> $stable(mem_addr)) else $error("recovery");
  a_no_fight:
  assert property (mem_data_oe |-> mem_oe_b) else $error("fight");
  a_drive_window:
  assert property ($rose(mem_data_oe) |-> !mem_we_b && !mem_sel_b) else $error("window");
  a_turn_gap:
  assert property ($rose(mem_data_oe) |-> $past(mem_oe_b) && $past(mem_oe_b, 2)) else $error("turn");
  c_read: cover property (rsp_valid);
  c_write: cover property ($fell(mem_we_b));
  c_wait: cover property (req_valid && !req_ready);
endmodule : sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva u_sram_host_ctrl_sva (.core_clk, .rst_b, .req_valid, .req_ready,
  .rsp_valid, .mem_addr, .mem_sel_b, .mem_oe_b, .mem_we_b, .mem_data_oe);
`default_nettype wire

/* dv/sram_host_ctrl_tb.sv */
// Bench for the RAM host controller
`default_nettype none
module sram_host_ctrl_tb
  import sram_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, rst_b = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_ready, rsp_valid;
  logic mem_sel_b, mem_oe_b, mem_we_b, mem_data_oe;
  logic [ADDR_W-1:0] req_addr = 11'h000, mem_addr;
  logic [DATA_W-1:0] req_wdata = 8'h00, rsp_rdata, mem_data_in, mem_data_out;
  int miscompares = 0, compares = 0;
  sram_host_ctrl u_sram_host_ctrl (.core_clk, .rst_b, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .mem_addr, .mem_sel_b, .mem_oe_b, .mem_we_b, .mem_data_in, .mem_data_out, .mem_data_oe);
  sram_model u_sram_model (.mem_addr, .mem_sel_b, .mem_oe_b, .mem_we_b, .mem_data_out, .mem_data_oe, .mem_data_in);
  initial forever #25 core_clk = ~core_clk;
  task chk(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task req(logic w, logic [10:0] a, logic [7:0] d);
    {req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
    while (!req_ready) @(negedge core_clk);
    @(negedge core_clk);
    req_valid = 1'h0;
  endtask : req
  task wr(logic [10:0] a, logic [7:0] d);
    logic [7:0] pulse;
    pulse = 8'h00;
    req(1'h1, a, d);
    repeat (8) begin
      if (!mem_we_b) begin
        pulse++;
        chk("bus", d, mem_data_in);
      end
      @(negedge core_clk);
    end
    chk("wpulse", {4'h0, WPULSE_CYC}, pulse);
  endtask : wr
  task rd(logic [10:0] a, logic [7:0] e);
    logic got;
    logic [7:0] n;
    logic [7:0] lat;
    got = 1'h0;
    n = 8'h00;
    lat = 8'h00;
    req(1'h0, a, 8'h00);
    repeat (8) begin
      if (rsp_valid) begin
        got = 1'h1;
        lat = n;
        chk("rdata", e, rsp_rdata);
      end
      n++;
      @(negedge core_clk);
    end
    chk("rsp", 8'h01, {7'h00, got});
    chk("rlat", {4'h0, READ_CYC}, lat);
  endtask : rd
  task sc_edges;
    chk("idle", 8'h01, {7'h00, mem_sel_b & ~mem_data_oe});
    wr(11'h000, 8'hA5);
    wr(11'h7FF, 8'h5A);
    rd(11'h000, 8'hA5);
    rd(11'h7FF, 8'h5A);
  endtask : sc_edges
  task sc_turn;
    wr(11'h123, 8'h3C);
    rd(11'h123, 8'h3C);
    wr(11'h123, 8'hC3);
    rd(11'h123, 8'hC3);
  endtask : sc_turn
  task sc_b2b;
    req(1'h1, 11'h2AA, 8'h96);
    @(negedge core_clk);
    rd(11'h2AA, 8'h96);
  endtask : sc_b2b
  task sc_reset;
    req(1'h1, 11'h055, 8'h69);
    @(negedge core_clk);
    rst_b = 1'h0;
    @(negedge core_clk);
    chk("rst_out", 8'h0E, {2'h0, req_ready, rsp_valid, mem_sel_b, mem_oe_b, mem_we_b, mem_data_oe});
    chk("rst_addr", 8'h00, mem_addr[7:0]);
    rst_b = 1'h1;
    @(negedge core_clk);
    chk("rst_ready", 8'h01, {7'h00, req_ready});
    wr(11'h056, 8'h87);
    rd(11'h056, 8'h87);
  endtask : sc_reset
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5) @(negedge core_clk);
    rst_b = 1'h1;
    @(negedge core_clk);
    sc_edges();
    sc_turn();
    sc_b2b();
    sc_reset();
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule : sram_host_ctrl_tb
`default_nettype wire
